// ---- hw/scd_pkg.sv ----
/*
  shared constants and types of the multi-mode pin configuration decoder:
  register map, pin classes, state codes, timing and the output voltage table.
  assumes the analog pin measurement front end reports one class and one
  resistor index per pin.
*/
package scd_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int CHECK_TIME_US = 5000;                    // memory check, least time
  localparam int CHECK_CYCLES  = CHECK_TIME_US * CLK_MHZ; // rounds up exactly

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OVR0   = 8'h08; // five override words from here
  localparam logic [7:0] REG_VOUT   = 8'h1c;
  localparam logic [7:0] REG_EFF    = 8'h20;
  localparam int         NUM_OVR    = 5;
  localparam int         OVR_FREQ   = 0;
  localparam int         OVR_RAMP   = 1;
  localparam int         OVR_VOUT   = 2;
  localparam int         OVR_PHASE  = 3;
  localparam int         OVR_COMP   = 4;
  localparam int         OVR_EN_BIT = 31;
  localparam int         CTRL_RESTORE_BIT = 0;
  localparam int         STAT_ERR_BIT     = 3;

  // ----------------------------------------
  // pins and classes
  // ----------------------------------------
  localparam int         NUM_PINS  = 5;
  localparam int         PIN_MODE  = 0;
  localparam int         PIN_ADDR  = 1;
  localparam int         PIN_FREQ  = 2;
  localparam int         PIN_RAMP  = 3;
  localparam int         PIN_VOUT  = 4;
  localparam logic [1:0] CLS_LOW   = 2'h0;
  localparam logic [1:0] CLS_OPEN  = 2'h1;
  localparam logic [1:0] CLS_HIGH  = 2'h2;
  localparam logic [1:0] CLS_RES   = 2'h3;
  localparam logic [4:0] RES_MAX   = 5'h1e;  // 31 selections, index 0..30
  localparam logic [5:0] SEL_RES0  = 6'h03;  // first resistor selection code
  localparam logic [4:0] MODE_SHARE_IDX = 5'h10; // 46.4k and above
  localparam logic [4:0] MODE_THREE_IDX = 5'h19; // three-phase groups from here
  localparam logic [6:0] ADDR_LOW  = 7'h23;
  localparam logic [6:0] ADDR_OPEN = 7'h24;
  localparam logic [6:0] ADDR_HIGH = 7'h25;
  localparam logic [6:0] ADDR_RES0 = 7'h50;
  localparam logic [8:0] PHASE_STEP_DEG = 9'h02d;   // 45 degrees
  localparam logic [8:0] PHASE_HALF_DEG = 9'h0b4;   // 180 degrees
  localparam logic [8:0] PHASE_THIRD_DEG = 9'h078;  // 120 degrees
  localparam logic [5:0] DEFAULT_FREQ_SEL = 6'h01;  // open strap setting
  localparam logic [15:0] VMAX_NUM = 16'h000b;      // limit is 11/10 of pin value
  localparam logic [15:0] VMAX_DEN = 16'h000a;

  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_LOAD  = 2'b01,
    ST_READY = 2'b10
  } scd_state_t;

  typedef struct packed {
    logic [1:0] cls;
    logic [4:0] idx;
  } scd_pin_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic        share;
    logic        reference;
    logic        threePhase;
    logic [8:0]  phaseDeg;
    logic [5:0]  freqSel;
    logic [5:0]  rampSel;
    logic [5:0]  compSel;
    logic [11:0] voutMv;
    logic [11:0] voutMaxMv;
  } scd_cfg_t;

  // output voltage in millivolts for a selection code
  function automatic logic [11:0] vout_mv(input logic [5:0] sel);
    case (sel)
      6'h00: vout_mv = 12'd1200; 6'h01: vout_mv = 12'd1500; 6'h02: vout_mv = 12'd3300;
      6'h03: vout_mv = 12'd600;  6'h04: vout_mv = 12'd650;  6'h05: vout_mv = 12'd700;
      6'h06: vout_mv = 12'd750;  6'h07: vout_mv = 12'd800;  6'h08: vout_mv = 12'd850;
      6'h09: vout_mv = 12'd900;  6'h0a: vout_mv = 12'd950;  6'h0b: vout_mv = 12'd1000;
      6'h0c: vout_mv = 12'd1050; 6'h0d: vout_mv = 12'd1100; 6'h0e: vout_mv = 12'd1150;
      6'h0f: vout_mv = 12'd1200; 6'h10: vout_mv = 12'd1250; 6'h11: vout_mv = 12'd1300;
      6'h12: vout_mv = 12'd1400; 6'h13: vout_mv = 12'd1500; 6'h14: vout_mv = 12'd1600;
      6'h15: vout_mv = 12'd1700; 6'h16: vout_mv = 12'd1800; 6'h17: vout_mv = 12'd1900;
      6'h18: vout_mv = 12'd2000; 6'h19: vout_mv = 12'd2100; 6'h1a: vout_mv = 12'd2200;
      6'h1b: vout_mv = 12'd2300; 6'h1c: vout_mv = 12'd2500; 6'h1d: vout_mv = 12'd2800;
      6'h1e: vout_mv = 12'd3000; 6'h1f: vout_mv = 12'd3300; 6'h20: vout_mv = 12'd3600;
      default: vout_mv = 12'd1500;
    endcase
  endfunction
endpackage

// ---- hw/scd_strap_decoder.sv ----
/*
  multi-mode pin configuration decoder with AHB-Lite register slave.
  assumes an analog front end that classifies each pin (low, open, high or
  resistor index) asynchronously, a serial bus front end that reports
  restore commands as a one-cycle pulse on mclk, and one AHB-Lite master.
*/
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module scd_strap_decoder #(
  parameter int CHECK_CYCLES = scd_pkg::CHECK_CYCLES
) (
  input  wire logic                              mclk,
  input  wire logic                              resetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic                              hready,
  input  wire logic [31:0]                       hwdata,
  output logic [31:0]                            hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  input  wire scd_pkg::scd_pin_t [scd_pkg::NUM_PINS-1:0] pinRaw,
  input  wire logic                              sclIn,
  input  wire logic                              enableIn,
  input  wire logic                              restoreCmd,
  input  wire logic                              faultIn,
  output logic                                   sclRiseOk,
  output logic                                   enableOk,
  output logic                                   cfgReady,
  output logic                                   loadDone,
  output scd_pkg::scd_cfg_t                      cfg,
  output logic                                   alertOut,
  output logic                                   alertOe
);
  localparam int CNT_W = $clog2(CHECK_CYCLES + 1);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  scd_pkg::scd_pin_t [scd_pkg::NUM_PINS-1:0] pinMeta;
  scd_pkg::scd_pin_t [scd_pkg::NUM_PINS-1:0] pinSync;
  logic [1:0] sclMeta;
  logic       sclSync;
  logic       sclPrev;
  logic [1:0] enMeta;

  // two flops per pin; pin classes change only when the front end resettles
  genvar gp;
  generate
    for (gp = 0; gp < scd_pkg::NUM_PINS; gp++) begin : g_pinSync
      always_ff @(posedge mclk) begin
        pinMeta[gp] <= pinRaw[gp];
        pinSync[gp] <= pinMeta[gp];
      end
    end
  endgenerate

  // serial clock sampled at 125 MHz, ample margin for 100k and 400k
  always_ff @(posedge mclk) begin
    sclMeta <= {sclMeta[0], sclIn};
    enMeta  <= {enMeta[0], enableIn};
    sclPrev <= sclMeta[1];
  end
  assign sclSync = sclMeta[1];

  // ----------------------------------------
  // sampling sequence
  // ----------------------------------------
  scd_pkg::scd_state_t state;
  scd_pkg::scd_state_t next_state;
  logic [CNT_W-1:0]    checkCnt;
  logic                restoreTrig;
  logic                ctrlRestore;
  logic                checkDone;

  assign restoreTrig = restoreCmd | ctrlRestore;
  assign checkDone   = (checkCnt == CNT_W'(CHECK_CYCLES - 1));

  // a restore restarts the check even in the middle of one
  always_comb begin
    next_state = state;
    case (state)
      scd_pkg::ST_CHECK: if (checkDone) next_state = scd_pkg::ST_LOAD;
      scd_pkg::ST_LOAD:  next_state = scd_pkg::ST_READY;
      scd_pkg::ST_READY: next_state = scd_pkg::ST_READY;
      default:           next_state = scd_pkg::ST_CHECK;
    endcase
    if (restoreTrig) begin
      next_state = scd_pkg::ST_CHECK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state    <= scd_pkg::ST_CHECK;
      checkCnt <= '0;
    end else begin
      state    <= next_state;
      checkCnt <= (state == scd_pkg::ST_CHECK && !restoreTrig) ? checkCnt + 1'b1 : '0;
    end
  end

  // traffic and enable pass only once the pins are loaded
  assign cfgReady  = (state == scd_pkg::ST_READY);
  assign sclRiseOk = cfgReady & sclSync & ~sclPrev;
  assign enableOk  = cfgReady & enMeta[1];

  // ----------------------------------------
  // pin decode
  // ----------------------------------------
  logic [5:0] sel [scd_pkg::NUM_PINS];
  logic [scd_pkg::NUM_PINS-1:0] pinBad;

  // strap levels give codes 0..2, resistors follow from code 3
  generate
    for (gp = 0; gp < scd_pkg::NUM_PINS; gp++) begin : g_sel
      assign sel[gp] = (pinSync[gp].cls == scd_pkg::CLS_RES) ?
                       scd_pkg::SEL_RES0 + {1'b0, pinSync[gp].idx} :
                       {4'h0, pinSync[gp].cls};
      assign pinBad[gp] = (pinSync[gp].cls == scd_pkg::CLS_RES) &&
                          (pinSync[gp].idx > scd_pkg::RES_MAX);
    end
  endgenerate

  scd_pkg::scd_pin_t modePin;
  scd_pkg::scd_pin_t addrPin;
  logic [6:0]  decAddr;
  logic        decShare;
  logic        decThree;
  logic [1:0]  decPos;
  logic        decRef;
  logic [8:0]  decPhase;
  logic [11:0] decVout;
  logic [15:0] vmaxProd;

  assign modePin = pinSync[scd_pkg::PIN_MODE];
  assign addrPin = pinSync[scd_pkg::PIN_ADDR];

  // address from the address pin alone
  assign decAddr = (addrPin.cls == scd_pkg::CLS_LOW)  ? scd_pkg::ADDR_LOW  :
                   (addrPin.cls == scd_pkg::CLS_OPEN) ? scd_pkg::ADDR_OPEN :
                   (addrPin.cls == scd_pkg::CLS_HIGH) ? scd_pkg::ADDR_HIGH :
                   scd_pkg::ADDR_RES0 + {2'h0, addrPin.idx};

  // sharing only for the upper resistor range of the mode pin
  assign decShare = (modePin.cls == scd_pkg::CLS_RES) &&
                    (modePin.idx >= scd_pkg::MODE_SHARE_IDX);
  assign decThree = decShare && (modePin.idx >= scd_pkg::MODE_THREE_IDX);

  // position within the group; strapped addresses act as the reference
  assign decPos = (addrPin.cls != scd_pkg::CLS_RES) ? 2'h0 :
                  decThree ? 2'(addrPin.idx % 5'd3) : {1'b0, addrPin.idx[0]};
  assign decRef = decShare && (decPos == 2'h0);

  // single phase spreads by address, sharing spreads across the group
  assign decPhase = !decShare ? 9'(decAddr[2:0] * scd_pkg::PHASE_STEP_DEG) :
                    decThree ? 9'(decPos * scd_pkg::PHASE_THIRD_DEG) :
                    9'(decPos * scd_pkg::PHASE_HALF_DEG);

  assign decVout  = scd_pkg::vout_mv(sel[scd_pkg::PIN_VOUT]);
  assign vmaxProd = 16'(decVout) * scd_pkg::VMAX_NUM;

  // ----------------------------------------
  // held pin configuration
  // ----------------------------------------
  scd_pkg::scd_cfg_t pinCfg;
  logic              cfgErr;
  logic              errClear;

  // captured once per load and held until the next sampling event
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pinCfg <= '0;
    end else if (state == scd_pkg::ST_LOAD) begin
      pinCfg.addr       <= decAddr;
      pinCfg.share      <= decShare;
      pinCfg.reference  <= decRef;
      pinCfg.threePhase <= decThree;
      pinCfg.phaseDeg   <= decPhase;
      pinCfg.freqSel    <= decShare ? scd_pkg::DEFAULT_FREQ_SEL :
                           sel[scd_pkg::PIN_FREQ];
      pinCfg.rampSel    <= sel[scd_pkg::PIN_RAMP];
      pinCfg.compSel    <= sel[scd_pkg::PIN_MODE];
      pinCfg.voutMv     <= decVout;
      pinCfg.voutMaxMv  <= 12'(vmaxProd / scd_pkg::VMAX_DEN);
    end
  end

  // sticky decode error, a new error beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfgErr <= 1'b0;
    end else begin
      cfgErr <= ((state == scd_pkg::ST_LOAD) && (|pinBad)) | (cfgErr & ~errClear);
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic [31:0] ovr [scd_pkg::NUM_OVR];
  logic        addrTaken;
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [31:0] rdMux;
  logic [7:0]  rdAddr;
  logic [11:0] ovrVout;

  assign addrTaken = hsel & hready & htrans[1];
  assign rdAddr    = haddr[7:0];
  assign hreadyout = 1'b1;     // zero wait states, every access answers at once
  assign hresp     = 1'b0;
  assign ctrlRestore = wrPend && (wrAddr == scd_pkg::REG_CTRL) &&
                       hwdata[scd_pkg::CTRL_RESTORE_BIT];
  assign errClear  = wrPend && (wrAddr == scd_pkg::REG_STATUS) &&
                     hwdata[scd_pkg::STAT_ERR_BIT];

  // read words; unmapped offsets read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (rdAddr)
      scd_pkg::REG_STATUS: rdMux = {17'h0, cfg.addr, 3'h0, alertOe, cfgErr,
                                    cfg.reference, cfg.share, cfgReady};
      scd_pkg::REG_VOUT:   rdMux = {4'h0, cfg.voutMaxMv, 4'h0, cfg.voutMv};
      scd_pkg::REG_EFF:    rdMux = {5'h0, cfg.phaseDeg, cfg.compSel, cfg.rampSel,
                                    cfg.freqSel};
      default: begin
        for (int i = 0; i < scd_pkg::NUM_OVR; i++) begin
          if (rdAddr == scd_pkg::REG_OVR0 + 8'(4 * i)) rdMux = ovr[i];
        end
      end
    endcase
  end

  // address phase latches the write target and the read word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend <= addrTaken & hwrite;
      wrAddr <= haddr[7:0];
      if (addrTaken && !hwrite) hrdata <= rdMux;
    end
  end

  // override words, cleared by every sampling event so pins take over again
  generate
    for (gp = 0; gp < scd_pkg::NUM_OVR; gp++) begin : g_ovr
      always_ff @(posedge mclk) begin
        if (!resetn || state == scd_pkg::ST_LOAD) begin
          ovr[gp] <= 32'h0000_0000;
        end else if (wrPend && wrAddr == scd_pkg::REG_OVR0 + 8'(4 * gp)) begin
          ovr[gp] <= hwdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // effective configuration
  // ----------------------------------------
  // override voltage is clamped to the pin limit, which software cannot move
  assign ovrVout = (ovr[scd_pkg::OVR_VOUT][11:0] > pinCfg.voutMaxMv) ?
                   pinCfg.voutMaxMv : ovr[scd_pkg::OVR_VOUT][11:0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg <= '0;
    end else begin
      cfg <= pinCfg;
      if (ovr[scd_pkg::OVR_FREQ][scd_pkg::OVR_EN_BIT])
        cfg.freqSel <= ovr[scd_pkg::OVR_FREQ][5:0];
      if (ovr[scd_pkg::OVR_RAMP][scd_pkg::OVR_EN_BIT])
        cfg.rampSel <= ovr[scd_pkg::OVR_RAMP][5:0];
      if (ovr[scd_pkg::OVR_COMP][scd_pkg::OVR_EN_BIT])
        cfg.compSel <= ovr[scd_pkg::OVR_COMP][5:0];
      if (ovr[scd_pkg::OVR_PHASE][scd_pkg::OVR_EN_BIT])
        cfg.phaseDeg <= ovr[scd_pkg::OVR_PHASE][8:0];
      if (ovr[scd_pkg::OVR_VOUT][scd_pkg::OVR_EN_BIT])
        cfg.voutMv <= ovrVout;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  // open-drain alert pulls low on a fault or a bad pin, only once ready
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      alertOe  <= 1'b0;
      loadDone <= 1'b0;
    end else begin
      alertOe  <= cfgReady & (faultIn | cfgErr);
      loadDone <= (state == scd_pkg::ST_LOAD);
    end
  end
  assign alertOut = 1'b0;  // open drain only ever drives low

endmodule
`default_nettype wire

// ---- verification/scd_strap_decoder_sva.sv ----
/*
  port checker of the pin configuration decoder, bound to every instance.
  assumes CHECK_CYCLES equals the parameter of the watched instance.
*/
`timescale 1ns/100ps
`default_nettype none
module scd_strap_decoder_sva #(
  parameter int CHECK_CYCLES = 20
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              enableIn,
  input wire logic              restoreCmd,
  input wire logic              faultIn,
  input wire logic              sclRiseOk,
  input wire logic              enableOk,
  input wire logic              cfgReady,
  input wire logic              loadDone,
  input wire scd_pkg::scd_cfg_t cfg,
  input wire logic              alertOe
);
  int lowCnt;
  // ----
  // length of the current busy stretch
  // ----
  always_ff @(posedge mclk) begin
    lowCnt <= (!resetn || cfgReady || restoreCmd) ? 0 : lowCnt + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // slack of three covers the load cycle and reset release alignment
  chk_check_len: assert property ($rose(cfgReady) |->
    lowCnt >= CHECK_CYCLES && lowCnt <= CHECK_CYCLES + 3) else $error("busy stretch length");
  chk_busy_quiet: assert property (!cfgReady |-> !sclRiseOk && !enableOk)
    else $error("bus or enable passed while busy");
  chk_alert_quiet: assert property (!cfgReady ##1 !cfgReady |-> !alertOe)
    else $error("alert driven while busy");
  chk_restore_take: assert property (restoreCmd && cfgReady |=> !cfgReady)
    else $error("restore did not start sampling");
  chk_load_after: assert property ($rose(cfgReady) |-> ##[0:1] loadDone)
    else $error("no load pulse after ready");
  chk_load_pulse: assert property (loadDone |=> !loadDone)
    else $error("load pulse too long");
  // cfg takes the new pin values one cycle after the load pulse
  chk_pin_hold: assert property (!$past(loadDone) |->
    $stable(cfg.addr) && $stable(cfg.voutMaxMv)) else $error("address or limit moved");
  chk_vmax_ratio: assert property (loadDone |=>
    16'(cfg.voutMaxMv) == 16'(cfg.voutMv) * 16'd11 / 16'd10) else $error("limit ratio wrong");
  chk_share_freq: assert property (loadDone ##1 cfg.share |->
    cfg.freqSel == scd_pkg::DEFAULT_FREQ_SEL) else $error("frequency pin used when sharing");
  chk_single_phase: assert property (loadDone ##1 !cfg.share |->
    cfg.phaseDeg == 9'(cfg.addr[2:0]) * 9'd45) else $error("single phase offset wrong");
  chk_alert_fault: assert property (cfgReady && faultIn |=> alertOe)
    else $error("fault not raised on alert");
  chk_enable_pass: assert property (enableIn[*3] ##0 cfgReady |-> enableOk)
    else $error("enable not passed when ready");
endmodule
bind scd_strap_decoder scd_strap_decoder_sva #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (
  .mclk, .resetn, .enableIn, .restoreCmd, .faultIn, .sclRiseOk, .enableOk, .cfgReady,
  .loadDone, .cfg, .alertOe);
`default_nettype wire

// ---- verification/scd_host_model.sv ----
/*
  far-side bus host: serial clock in frames, restore as a mclk pulse.
  assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module scd_host_model (
  input  wire logic mclk,
  output var logic  sclOut,
  output var logic  restoreCmd
);
  int gapCycles = 6; // scaled quiet time owed after a restore
  // idle bus: clock pulled up, no command
  initial begin
    sclOut = 1'b1;
    restoreCmd = 1'b0;
  end
  // restore pulse, then stay off the bus for the gap
  task automatic restore();
    @(posedge mclk);
    restoreCmd <= 1'b1;
    @(posedge mclk);
    restoreCmd <= 1'b0;
    repeat (gapCycles) @(posedge mclk);
  endtask
  // n clock pulses; a longer half period models a slow host
  task automatic frame(input int n, input int halfNs);
    repeat (n) begin
      #(halfNs) sclOut = 1'b0;
      #(halfNs) sclOut = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_scd_strap_decoder.sv ----
/*
  self-checking bench of the pin configuration decoder.
  assumes the host model drives the serial clock and restore pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_scd_strap_decoder;
  localparam int                CHK = 64; // short memory check keeps the run brief
  localparam scd_pkg::scd_pin_t OPN = 7'h20;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    hsel = 1'b0;
  logic                    hwrite = 1'b0;
  logic [1:0]              htrans = 2'h0;
  logic [31:0]             haddr = 32'h0;
  logic [31:0]             hwdata = 32'h0;
  logic                    enableIn = 1'b0;
  logic                    faultIn = 1'b0;
  scd_pkg::scd_pin_t [4:0] pinRaw;
  logic [31:0]             hrdata, rd;
  logic                    hreadyout, hresp, sclIn, restoreCmd, sclRiseOk;
  logic                    enableOk, cfgReady, loadDone, alertOut, alertOe;
  scd_pkg::scd_cfg_t       cfg;
  int                      bad_count = 0;
  int                      tests_run = 0;
  int                      rises = 0;

  scd_strap_decoder #(.CHECK_CYCLES(CHK)) dut (
    .mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .pinRaw, .sclIn, .enableIn, .restoreCmd,
    .faultIn, .sclRiseOk, .enableOk, .cfgReady, .loadDone, .cfg, .alertOut, .alertOe);
  scd_host_model host (.mclk, .sclOut(sclIn), .restoreCmd);

  // ----
  // clock, serial clock edge counter, watchdog
  // ----
  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (sclRiseOk === 1'b1) rises++;
  end
  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // single word transfer; readback lags a write, so idle afterwards
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait_load();
    int n = 0;
    while (loadDone !== 1'b1 && n++ < 4 * CHK) @(negedge mclk);
    check(32'(loadDone), 32'h1);
    @(negedge mclk); // cfg follows one cycle after the load pulse
  endtask
  task automatic load(input scd_pkg::scd_pin_t [4:0] p);
    @(posedge mclk);
    pinRaw <= p;
    repeat (4) @(posedge mclk); // pins settle through the synchronisers
    host.restore();
    wait_load();
  endtask
  function automatic scd_pkg::scd_pin_t pin(input logic [1:0] c, input int i);
    return {c, 5'(i)};
  endfunction

  // ----
  // scenarios
  // ----
  task automatic t_power_up();
    enableIn <= 1'b1;
    repeat (8) @(posedge mclk);
    check(32'(enableOk), 32'h0);
    wait_load();
    check(32'(cfg.addr), 32'h50);
    check(32'(cfg.freqSel), 32'h1);
    check(32'(cfg.rampSel), 32'h1);
    check(32'(cfg.voutMaxMv), 32'd825);
    repeat (4) @(negedge mclk);
    check(32'(enableOk), 32'h1);
    $display("test power_up done");
  endtask
  task automatic t_addr();
    scd_pkg::scd_pin_t a;
    logic [6:0] e;
    for (int k = 0; k < 34; k++) begin
      a = (k < 3) ? pin(2'(k), 0) : pin(scd_pkg::CLS_RES, k - 3);
      e = (k < 3) ? 7'h23 + 7'(k) : 7'h50 + 7'(k - 3);
      load({7'h63, OPN, OPN, a, OPN});
      check(32'(cfg.addr), 32'(e));
      check(32'(cfg.phaseDeg), 32'(e[2:0]) * 45);
    end
    $display("test addr done");
  endtask
  task automatic t_mode();
    logic [6:0] mc[7] = '{7'h00, 7'h6f, 7'h70, 7'h78, 7'h79, 7'h7e, 7'h40};
    logic [6:0] vc[7] = '{7'h00, 7'h40, 7'h60, 7'h6f, 7'h7d, 7'h20, 7'h63};
    int         ai[7] = '{2, 3, 3, 2, 4, 5, 1};
    int         sh[7] = '{0, 0, 1, 1, 1, 1, 0};
    int         ph[7] = '{90, 135, 180, 0, 120, 240, 45};
    int         mv[7] = '{1200, 3300, 600, 1400, 3600, 1500, 750};
    for (int k = 0; k < 7; k++) begin
      load({vc[k], 7'h40, 7'h40, pin(scd_pkg::CLS_RES, ai[k]), mc[k]});
      check(32'(cfg.share), 32'(sh[k]));
      check(32'(cfg.phaseDeg), 32'(ph[k]));
      check(32'(cfg.freqSel), sh[k] ? 32'h1 : 32'h2);
      check(32'(cfg.rampSel), 32'h2);
      check(32'(cfg.voutMv), 32'(mv[k]));
      check(32'(cfg.voutMaxMv), 32'(mv[k] * 11 / 10));
      if (sh[k] == 1) begin
        check(32'(cfg.reference), 32'(ph[k] == 0));
        check(32'(cfg.threePhase), 32'(k > 3));
      end
    end
    $display("test mode done");
  endtask
  task automatic t_regs();
    load({7'h63, OPN, OPN, 7'h61, OPN});
    ahb(1'b0, 32'(scd_pkg::REG_STATUS), 32'h0, rd);
    check(rd & 32'h7f01, 32'h5101);
    ahb(1'b1, 32'(scd_pkg::REG_OVR0), 32'h8000_0005, rd);
    check(32'(cfg.freqSel), 32'h5);
    ahb(1'b1, 32'(scd_pkg::REG_OVR0) + 32'h8, 32'h8000_0ce4, rd); // asks 3300 mV
    ahb(1'b0, 32'(scd_pkg::REG_VOUT), 32'h0, rd);
    check(rd, 32'h0339_0339);
    ahb(1'b0, 32'h40, 32'h0, rd);
    check(rd, 32'h0);
    pinRaw[1] <= pin(scd_pkg::CLS_RES, 7);
    repeat (8) @(posedge mclk);
    check(32'(cfg.addr), 32'h51);
    ahb(1'b1, 32'(scd_pkg::REG_CTRL), 32'h1, rd);
    wait_load();
    check(32'(cfg.addr), 32'h57);
    check(32'(cfg.freqSel), 32'h1);
    check(32'(cfg.voutMv), 32'd750);
    $display("test regs done");
  endtask
  task automatic t_alert();
    @(posedge mclk);
    faultIn <= 1'b1;
    repeat (3) @(posedge mclk);
    check(32'(alertOe), 32'h1);
    check(32'(alertOut), 32'h0);
    faultIn <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(alertOe), 32'h0);
    // ramp pin at the unused index 31 raises the sticky error
    load({7'h63, 7'h7f, OPN, 7'h61, OPN});
    ahb(1'b0, 32'(scd_pkg::REG_STATUS), 32'h0, rd);
    check(rd & 32'h18, 32'h18);
    ahb(1'b1, 32'(scd_pkg::REG_STATUS), 32'h8, rd);
    check(32'(alertOe), 32'h0);
    $display("test alert done");
  endtask
  task automatic t_link();
    rises = 0;
    host.frame(8, 80);
    host.frame(4, 80); // second frame straight after the first
    repeat (4) @(posedge mclk);
    check(rises, 12);
    host.restore();
    rises = 0;
    host.frame(2, 80);
    repeat (4) @(posedge mclk);
    check(rises, 0);
    wait_load();
    $display("test link done");
  endtask

  initial begin
    pinRaw = {7'h63, OPN, OPN, 7'h60, OPN};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_power_up();
    t_addr();
    t_mode();
    t_regs();
    t_alert();
    t_link();
    stop_test();
  end
endmodule
`default_nettype wire
